// file: hw/lpdc_host.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - space activates to different banks apart
// - wait after write data before read
// - wait one clock after power-down exit
// - wait after self refresh exit
// - honour write recovery before precharge
// - auto-precharge write to activate delay
// - auto-precharge only once activate-to-precharge met
// - drive write strobe preamble
// - drive write strobe postamble in range
// - strobe valid at the write command
// - one strobe and mask per byte
// - keep clock duty within limits
// - clock enable high during refresh
module lpdc_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire lpdc_pkg::lpdc_cmd_e req_cmd,
  input wire logic [lpdc_pkg::BA_W-1:0] req_bank,
  input wire logic [lpdc_pkg::A_W-1:0] req_addr,
  input wire logic [lpdc_pkg::DQ_W*lpdc_pkg::BEATS-1:0] req_wdata,
  input wire logic [lpdc_pkg::LANES*lpdc_pkg::BEATS-1:0] req_wmask,
  output logic rd_valid,
  output logic [lpdc_pkg::DQ_W*lpdc_pkg::BEATS-1:0] rd_data,
  output logic mem_ck,
  output logic mem_ck_n,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [lpdc_pkg::BA_W-1:0] mem_ba,
  output logic [lpdc_pkg::A_W-1:0] mem_a,
  output logic [lpdc_pkg::DQ_W-1:0] mem_dq_o,
  output logic [lpdc_pkg::LANES-1:0] mem_dq_oe,
  input wire logic [lpdc_pkg::DQ_W-1:0] mem_dq_i,
  output logic [lpdc_pkg::LANES-1:0] mem_dqs_o,
  output logic [lpdc_pkg::LANES-1:0] mem_dqs_oe,
  output logic [lpdc_pkg::LANES-1:0] mem_dm_o
);
  localparam int WD_W = lpdc_pkg::DQ_W * lpdc_pkg::BEATS;
  localparam int WM_W = lpdc_pkg::LANES * lpdc_pkg::BEATS;
  localparam int IDX_W = 2;

  lpdc_tmr_if ti ();

  logic ck_r;
  logic ck_n_r;
  logic ready_r;
  logic pend_r;
  lpdc_pkg::lpdc_cmd_e pcmd_r;
  logic [lpdc_pkg::BA_W-1:0] pbank_r;
  logic [lpdc_pkg::A_W-1:0] paddr_r;
  logic [WD_W-1:0] pwdata_r;
  logic [WM_W-1:0] pmask_r;
  lpdc_pkg::lpdc_pwr_e pwr_r;
  logic cke_r;
  logic [3:0] pins_r;
  logic [lpdc_pkg::BA_W-1:0] ba_r;
  logic [lpdc_pkg::A_W-1:0] a_r;
  logic wact_r;
  logic [lpdc_pkg::SEQ_W-1:0] wcnt_r;
  logic [WD_W-1:0] wbuf_r;
  logic [WM_W-1:0] wmask_r;
  logic [lpdc_pkg::DQ_W-1:0] dq_o_r;
  logic [lpdc_pkg::LANES-1:0] dq_oe_r;
  logic [lpdc_pkg::LANES-1:0] dqs_o_r;
  logic [lpdc_pkg::LANES-1:0] dqs_oe_r;
  logic [lpdc_pkg::LANES-1:0] dm_r;
  logic ract_r;
  logic [lpdc_pkg::SEQ_W-1:0] rcnt_r;
  logic [lpdc_pkg::DQ_W-1:0] dq_s1_r;
  logic [lpdc_pkg::DQ_W-1:0] dq_s2_r;
  logic [WD_W-1:0] rbuf_r;
  logic rd_valid_r;

  logic slot;
  logic go;
  logic exit_now;
  logic busy;
  logic ap;
  logic [3:0] pins_nxt;

  function automatic logic in_win(input logic [lpdc_pkg::SEQ_W-1:0] v,
                                  input logic [lpdc_pkg::SEQ_W-1:0] lo,
                                  input logic [lpdc_pkg::SEQ_W-1:0] hi);
    return v >= lo && v <= hi;
  endfunction : in_win

  function automatic logic [IDX_W-1:0] beat_idx(input logic [lpdc_pkg::SEQ_W-1:0] v,
                                               input logic [lpdc_pkg::SEQ_W-1:0] first);
    return IDX_W'(v - first);
  endfunction : beat_idx

  lpdc_timers u_tmr (
    .clk(clk),
    .resetn(resetn),
    .t(ti.tmr)
  );

  // ============================================================
  // link clock divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ck_r <= 1'b0;
      ck_n_r <= 1'b1;
    end else begin
      ck_r <= ~ck_r;
      ck_n_r <= ck_r;
    end
  end

  // commands change as the link clock falls
  assign slot = ck_r;
  assign busy = wact_r || ract_r;
  assign ap = paddr_r[lpdc_pkg::AP_BIT];

  // ============================================================
  // request intake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      ready_r <= 1'b1;
      pcmd_r <= lpdc_pkg::C_EXIT;
      pbank_r <= '0;
      paddr_r <= '0;
      pwdata_r <= '0;
      pmask_r <= '0;
    end else if (req_valid && ready_r) begin
      pend_r <= 1'b1;
      ready_r <= 1'b0;
      pcmd_r <= req_cmd;
      pbank_r <= req_bank;
      paddr_r <= req_addr;
      pwdata_r <= req_wdata;
      pmask_r <= req_wmask;
    end else if (go) begin
      pend_r <= 1'b0;
      ready_r <= 1'b1;
    end
  end

  // ============================================================
  // scheduler
  always_comb begin
    go = 1'b0;
    exit_now = 1'b0;
    pins_nxt = lpdc_pkg::PIN_NOP;
    ti.tick = slot;
    ti.bank = pbank_r;
    ti.a10 = ap;
    ti.ld_act = 1'b0;
    ti.ld_rd = 1'b0;
    ti.ld_wr = 1'b0;
    ti.ld_pre = 1'b0;
    ti.ld_ref = 1'b0;
    ti.ld_pdx = 1'b0;
    ti.ld_srx = 1'b0;
    if (slot && pend_r) begin
      if (pwr_r != lpdc_pkg::P_RUN) begin
        exit_now = 1'b1;
        ti.ld_pdx = pwr_r == lpdc_pkg::P_PD;
        ti.ld_srx = pwr_r == lpdc_pkg::P_SR;
      end else if (ti.cmd_ok) begin
        unique case (pcmd_r)
          lpdc_pkg::C_ACT: begin
            if (ti.act_ok[pbank_r]) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_ACT;
              ti.ld_act = 1'b1;
            end
          end
          lpdc_pkg::C_READ: begin
            if (ti.rw_ok[pbank_r] && ti.rd_ok && !busy && (!ap || ti.ap_ok[pbank_r])) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_RD;
              ti.ld_rd = 1'b1;
            end
          end
          lpdc_pkg::C_WRITE: begin
            if (ti.rw_ok[pbank_r] && !busy && (!ap || ti.ap_ok[pbank_r])) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_WR;
              ti.ld_wr = 1'b1;
            end
          end
          lpdc_pkg::C_PRE: begin
            if (ap ? &ti.pre_ok : ti.pre_ok[pbank_r]) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_PRE;
              ti.ld_pre = 1'b1;
            end
          end
          lpdc_pkg::C_REF: begin
            if (&ti.rp_ok && !busy) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_REF;
              ti.ld_ref = 1'b1;
            end
          end
          lpdc_pkg::C_PDE: begin
            go = !busy;
          end
          lpdc_pkg::C_SRE: begin
            if (&ti.rp_ok && !busy) begin
              go = 1'b1;
              pins_nxt = lpdc_pkg::PIN_REF;
            end
          end
          lpdc_pkg::C_EXIT: begin
            go = 1'b1;
          end
        endcase
      end
    end
  end

  // ============================================================
  // power state and clock enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_r <= lpdc_pkg::P_RUN;
      cke_r <= 1'b1;
    end else if (exit_now) begin
      pwr_r <= lpdc_pkg::P_RUN;
      cke_r <= 1'b1;
    end else if (go && pcmd_r == lpdc_pkg::C_PDE) begin
      pwr_r <= lpdc_pkg::P_PD;
      cke_r <= 1'b0;
    end else if (go && pcmd_r == lpdc_pkg::C_SRE) begin
      pwr_r <= lpdc_pkg::P_SR;
      cke_r <= 1'b0;
    end
  end

  // ============================================================
  // command pins, one link clock per command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_r <= lpdc_pkg::PIN_NOP;
      ba_r <= '0;
      a_r <= '0;
    end else if (slot) begin
      pins_r <= pins_nxt;
      if (go) begin
        ba_r <= pbank_r;
        a_r <= paddr_r;
      end
    end
  end

  // ============================================================
  // write burst sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wact_r <= 1'b0;
      wcnt_r <= '0;
      wbuf_r <= '0;
      wmask_r <= '0;
    end else if (ti.ld_wr) begin
      wact_r <= 1'b1;
      wcnt_r <= lpdc_pkg::SEQ_W'(1);
      wbuf_r <= pwdata_r;
      wmask_r <= pmask_r;
    end else if (wact_r) begin
      wcnt_r <= wcnt_r + 1'b1;
      wact_r <= wcnt_r != lpdc_pkg::WS_END;
    end
  end

  // strobes: low from the command, toggle per beat, half-clock postamble
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dqs_o_r <= '0;
      dqs_oe_r <= '0;
    end else if (ti.ld_wr) begin
      dqs_oe_r <= '1;
      dqs_o_r <= '0;
    end else if (wact_r) begin
      if (in_win(wcnt_r, lpdc_pkg::WS_DQS_FIRST, lpdc_pkg::WS_DQS_LAST)) begin
        dqs_o_r <= {lpdc_pkg::LANES{wcnt_r[0]}};
      end
      if (wcnt_r == lpdc_pkg::WS_END) begin
        dqs_oe_r <= '0;
      end
    end
  end

  // data and masks, lane by lane
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_o_r <= '0;
      dq_oe_r <= '0;
      dm_r <= '0;
    end else if (wact_r && in_win(wcnt_r, lpdc_pkg::WS_DQ_FIRST, lpdc_pkg::WS_DQ_LAST)) begin
      for (int l = 0; l < lpdc_pkg::LANES; l++) begin
        dq_oe_r[l] <= 1'b1;
        dq_o_r[l*lpdc_pkg::LANE_W +: lpdc_pkg::LANE_W] <=
          wbuf_r[beat_idx(wcnt_r, lpdc_pkg::WS_DQ_FIRST)*lpdc_pkg::DQ_W + l*lpdc_pkg::LANE_W +: lpdc_pkg::LANE_W];
        dm_r[l] <= wmask_r[beat_idx(wcnt_r, lpdc_pkg::WS_DQ_FIRST)*lpdc_pkg::LANES + l];
      end
    end else begin
      dq_oe_r <= '0;
      dm_r <= '0;
    end
  end

  // ============================================================
  // read return
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ract_r <= 1'b0;
      rcnt_r <= '0;
    end else if (ti.ld_rd) begin
      ract_r <= 1'b1;
      rcnt_r <= lpdc_pkg::SEQ_W'(1);
    end else if (ract_r) begin
      rcnt_r <= rcnt_r + 1'b1;
      ract_r <= rcnt_r != lpdc_pkg::RS_END;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rbuf_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= ract_r && rcnt_r == lpdc_pkg::RS_END;
      if (ract_r && in_win(rcnt_r, lpdc_pkg::RS_CAP_FIRST, lpdc_pkg::RS_CAP_LAST)) begin
        rbuf_r[beat_idx(rcnt_r, lpdc_pkg::RS_CAP_FIRST)*lpdc_pkg::DQ_W +: lpdc_pkg::DQ_W] <= dq_s2_r;
      end
    end
  end

  // ============================================================
  // outputs
  assign req_ready = ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rbuf_r;
  assign mem_ck = ck_r;
  assign mem_ck_n = ck_n_r;
  assign mem_cke = cke_r;
  assign mem_cs_n = pins_r[3];
  assign mem_ras_n = pins_r[2];
  assign mem_cas_n = pins_r[1];
  assign mem_we_n = pins_r[0];
  assign mem_ba = ba_r;
  assign mem_a = a_r;
  assign mem_dq_o = dq_o_r;
  assign mem_dq_oe = dq_oe_r;
  assign mem_dqs_o = dqs_o_r;
  assign mem_dqs_oe = dqs_oe_r;
  assign mem_dm_o = dm_r;
endmodule : lpdc_host
`default_nettype wire

// file: hw/lpdc_pkg.sv
// ============================================================
// shared constants and types
package lpdc_pkg;
  // ============================================================
  // widths
  localparam int NBANK = 4;
  localparam int BA_W = 2;
  localparam int A_W = 13;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int BEATS = 4;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 8;
  localparam int SEQ_W = 4;
  typedef logic [CNT_W-1:0] lpdc_cnt_t;

  // ============================================================
  // clocking
  localparam int CLK_PS = 100000;
  localparam int CK_DIV = 2;
  localparam int TCK_PS = CLK_PS * CK_DIV;
  localparam bit FAST_GRADE = 1'b0;

  // ============================================================
  // times in ps or in clocks, figures as printed
  localparam int RRD_F_PS = 12000;
  localparam int RRD_S_PS = 15000;
  localparam int WR_F_PS = 12000;
  localparam int WR_S_PS = 15000;
  localparam int RAS_F_PS = 42000;
  localparam int RAS_S_PS = 45000;
  localparam int RP_F_PS = 18000;
  localparam int RP_S_PS = 22500;
  localparam int RCD_F_PS = 18000;
  localparam int RCD_S_PS = 22500;
  localparam int RFC_PS = 70000;
  localparam int XSR_PS = 120000;
  localparam int XSR_MIN_CK = 2;
  localparam int WTR_CK = 1;
  localparam int XP_CK = 1;
  localparam int WL_CK = 1;
  localparam int BURST_CK = 2;

  // ps minimum to whole link clocks, rounded up, never below one
  function automatic int ps_to_ck(input int ps);
    int n;
    n = (ps + TCK_PS - 1) / TCK_PS;
    return (n < 1) ? 1 : n;
  endfunction : ps_to_ck

  localparam int T_RRD = ps_to_ck(FAST_GRADE ? RRD_F_PS : RRD_S_PS);
  localparam int T_WR = ps_to_ck(FAST_GRADE ? WR_F_PS : WR_S_PS);
  localparam int T_RAS = ps_to_ck(FAST_GRADE ? RAS_F_PS : RAS_S_PS);
  localparam int T_RP = ps_to_ck(FAST_GRADE ? RP_F_PS : RP_S_PS);
  localparam int T_RCD = ps_to_ck(FAST_GRADE ? RCD_F_PS : RCD_S_PS);
  localparam int T_RFC = ps_to_ck(RFC_PS);
  localparam int T_XSR0 = ps_to_ck(XSR_PS);
  localparam int T_XSR = (T_XSR0 < XSR_MIN_CK) ? XSR_MIN_CK : T_XSR0;
  localparam int T_DAL = T_WR + T_RP;

  // ============================================================
  // timer load values (spacing minus one)
  localparam lpdc_cnt_t L_RRD = CNT_W'(T_RRD - 1);
  localparam lpdc_cnt_t L_RAS = CNT_W'(T_RAS - 1);
  localparam lpdc_cnt_t L_RP = CNT_W'(T_RP - 1);
  localparam lpdc_cnt_t L_RCD = CNT_W'(T_RCD - 1);
  localparam lpdc_cnt_t L_RFC = CNT_W'(T_RFC - 1);
  localparam lpdc_cnt_t L_XP = CNT_W'(XP_CK - 1);
  localparam lpdc_cnt_t L_XSR = CNT_W'(T_XSR - 1);
  localparam lpdc_cnt_t L_WTR = CNT_W'(WL_CK + BURST_CK + WTR_CK - 1);
  localparam lpdc_cnt_t L_WREC = CNT_W'(WL_CK + BURST_CK + T_WR - 1);
  localparam lpdc_cnt_t L_WDAL = CNT_W'(WL_CK + BURST_CK + T_DAL - 1);
  localparam lpdc_cnt_t L_RDAP = CNT_W'(BURST_CK + T_RP - 1);
  localparam lpdc_cnt_t L_RDPRE = CNT_W'(BURST_CK - 1);

  // ============================================================
  // burst sequencer positions, in clk cycles after the command
  localparam logic [SEQ_W-1:0] WS_DQ_FIRST = 4'h2;
  localparam logic [SEQ_W-1:0] WS_DQ_LAST = 4'h5;
  localparam logic [SEQ_W-1:0] WS_DQS_FIRST = 4'h3;
  localparam logic [SEQ_W-1:0] WS_DQS_LAST = 4'h6;
  localparam logic [SEQ_W-1:0] WS_END = 4'h7;
  localparam logic [SEQ_W-1:0] RS_CAP_FIRST = 4'h8;
  localparam logic [SEQ_W-1:0] RS_CAP_LAST = 4'hb;
  localparam logic [SEQ_W-1:0] RS_END = 4'hc;

  // ============================================================
  // pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;

  typedef enum logic [2:0] {
    C_ACT = 3'b000,
    C_READ = 3'b001,
    C_WRITE = 3'b010,
    C_PRE = 3'b011,
    C_REF = 3'b100,
    C_PDE = 3'b101,
    C_SRE = 3'b110,
    C_EXIT = 3'b111
  } lpdc_cmd_e;

  typedef enum logic [1:0] {
    P_RUN = 2'b00,
    P_PD = 2'b01,
    P_SR = 2'b10
  } lpdc_pwr_e;
endpackage : lpdc_pkg

// file: hw/lpdc_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// scheduler to timer bank
interface lpdc_tmr_if;
  logic tick;
  logic ld_act;
  logic ld_rd;
  logic ld_wr;
  logic ld_pre;
  logic ld_ref;
  logic ld_pdx;
  logic ld_srx;
  logic a10;
  logic [lpdc_pkg::BA_W-1:0] bank;
  logic [lpdc_pkg::NBANK-1:0] act_ok;
  logic [lpdc_pkg::NBANK-1:0] rw_ok;
  logic [lpdc_pkg::NBANK-1:0] pre_ok;
  logic [lpdc_pkg::NBANK-1:0] ap_ok;
  logic [lpdc_pkg::NBANK-1:0] rp_ok;
  logic rd_ok;
  logic cmd_ok;
  modport ctl (output tick, ld_act, ld_rd, ld_wr, ld_pre, ld_ref, ld_pdx, ld_srx, a10, bank,
               input act_ok, rw_ok, pre_ok, ap_ok, rp_ok, rd_ok, cmd_ok);
  modport tmr (input tick, ld_act, ld_rd, ld_wr, ld_pre, ld_ref, ld_pdx, ld_srx, a10, bank,
               output act_ok, rw_ok, pre_ok, ap_ok, rp_ok, rd_ok, cmd_ok);
endinterface : lpdc_tmr_if
`default_nettype wire

// file: hw/lpdc_timers.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// per-bank and global spacing timers
module lpdc_timers (
  input wire logic clk,
  input wire logic resetn,
  lpdc_tmr_if.tmr t
);
  lpdc_pkg::lpdc_cnt_t rcd_r [lpdc_pkg::NBANK];
  lpdc_pkg::lpdc_cnt_t ras_r [lpdc_pkg::NBANK];
  lpdc_pkg::lpdc_cnt_t rp_r [lpdc_pkg::NBANK];
  lpdc_pkg::lpdc_cnt_t wrr_r [lpdc_pkg::NBANK];
  lpdc_pkg::lpdc_cnt_t rrd_r;
  lpdc_pkg::lpdc_cnt_t wtr_r;
  lpdc_pkg::lpdc_cnt_t gate_r;

  function automatic lpdc_pkg::lpdc_cnt_t step(input lpdc_pkg::lpdc_cnt_t c, input logic tk);
    return (tk && c != '0) ? c - 1'b1 : c;
  endfunction : step

  // ============================================================
  // per-bank timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < lpdc_pkg::NBANK; b++) begin
        rcd_r[b] <= '0;
        ras_r[b] <= '0;
        rp_r[b] <= '0;
        wrr_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < lpdc_pkg::NBANK; b++) begin
        if (t.ld_act && t.bank == lpdc_pkg::BA_W'(b)) begin
          rcd_r[b] <= lpdc_pkg::L_RCD;
          ras_r[b] <= lpdc_pkg::L_RAS;
        end else begin
          rcd_r[b] <= step(rcd_r[b], t.tick);
          ras_r[b] <= step(ras_r[b], t.tick);
        end
        if (t.ld_pre && (t.a10 || t.bank == lpdc_pkg::BA_W'(b))) begin
          rp_r[b] <= lpdc_pkg::L_RP;
        end else if (t.ld_wr && t.a10 && t.bank == lpdc_pkg::BA_W'(b)) begin
          rp_r[b] <= lpdc_pkg::L_WDAL;
        end else if (t.ld_rd && t.a10 && t.bank == lpdc_pkg::BA_W'(b)) begin
          rp_r[b] <= lpdc_pkg::L_RDAP;
        end else begin
          rp_r[b] <= step(rp_r[b], t.tick);
        end
        if (t.ld_wr && t.bank == lpdc_pkg::BA_W'(b)) begin
          wrr_r[b] <= lpdc_pkg::L_WREC;
        end else if (t.ld_rd && t.bank == lpdc_pkg::BA_W'(b)) begin
          wrr_r[b] <= lpdc_pkg::L_RDPRE;
        end else begin
          wrr_r[b] <= step(wrr_r[b], t.tick);
        end
      end
    end
  end

  // ============================================================
  // global timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rrd_r <= '0;
      wtr_r <= '0;
      gate_r <= '0;
    end else begin
      rrd_r <= t.ld_act ? lpdc_pkg::L_RRD : step(rrd_r, t.tick);
      wtr_r <= t.ld_wr ? lpdc_pkg::L_WTR : step(wtr_r, t.tick);
      if (t.ld_ref) begin
        gate_r <= lpdc_pkg::L_RFC;
      end else if (t.ld_pdx) begin
        gate_r <= lpdc_pkg::L_XP;
      end else if (t.ld_srx) begin
        gate_r <= lpdc_pkg::L_XSR;
      end else begin
        gate_r <= step(gate_r, t.tick);
      end
    end
  end

  // ============================================================
  // readiness flags
  always_comb begin
    for (int b = 0; b < lpdc_pkg::NBANK; b++) begin
      t.rp_ok[b] = rp_r[b] == '0;
      t.act_ok[b] = rp_r[b] == '0 && rrd_r == '0;
      t.rw_ok[b] = rcd_r[b] == '0;
      t.pre_ok[b] = ras_r[b] == '0 && wrr_r[b] == '0;
      t.ap_ok[b] = ras_r[b] == '0;
    end
    t.rd_ok = wtr_r == '0;
    t.cmd_ok = gate_r == '0;
  end
endmodule : lpdc_timers
`default_nettype wire

// file: verification/lpdc_host_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// link timing checks
module lpdc_host_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd_valid,
  input wire logic mem_ck,
  input wire logic mem_ck_n,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [lpdc_pkg::BA_W-1:0] mem_ba,
  input wire logic [lpdc_pkg::A_W-1:0] mem_a,
  input wire logic [lpdc_pkg::LANES-1:0] mem_dq_oe,
  input wire logic [lpdc_pkg::LANES-1:0] mem_dqs_o,
  input wire logic [lpdc_pkg::LANES-1:0] mem_dqs_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [3:0] cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  wire is_wr = cmd == lpdc_pkg::PIN_WR;
  wire is_rd = cmd == lpdc_pkg::PIN_RD;
  wire is_act = cmd == lpdc_pkg::PIN_ACT;
  wire is_pre = cmd == lpdc_pkg::PIN_PRE;
  wire is_ref = cmd == lpdc_pkg::PIN_REF;
  wire is_nop = cmd == lpdc_pkg::PIN_NOP;
  logic sr_r;
  logic [3:0] dal_r;
  logic [1:0] wba_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      sr_r <= 1'b0;
    else if (mem_cke)
      sr_r <= 1'b0;
    else if (is_ref)
      sr_r <= 1'b1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dal_r <= 4'h0;
      wba_r <= 2'h0;
    end else if ($rose(is_wr)) begin
      dal_r <= mem_a[lpdc_pkg::AP_BIT] ? 4'h9 : 4'h0;
      wba_r <= mem_ba;
    end else if (dal_r != 4'h0)
      dal_r <= dal_r - 4'h1;
  end
  cmd_slot_a: assert property (cmd != $past(cmd) |-> $fell(mem_ck))
    else $error("command changed off a slot edge");
  ck_shape_a: assert property (resetn |=> mem_ck != $past(mem_ck) && mem_ck_n == ~mem_ck)
    else $error("link clock not even and complementary");
  ref_cke_a: assert property ($rose(is_ref) && mem_cke |=> mem_cke)
    else $error("clock enable dropped in refresh");
  wtr_gap_a: assert property ($rose(is_wr) |-> !is_rd [*8])
    else $error("read too soon after write");
  wrec_gap_a: assert property ($rose(is_wr) |-> (!is_pre || (mem_ba != wba_r && !mem_a[10])) [*8])
    else $error("precharge inside write recovery");
  dal_gap_a: assert property (is_act && mem_ba == wba_r |-> dal_r == 4'h0)
    else $error("activate inside auto precharge delay");
  wpre_a: assert property ($rose(is_wr) |-> mem_dqs_oe == 2'h3 && mem_dqs_o == 2'h0
    ##2 mem_dq_oe == 2'h3 && mem_dqs_o == 2'h0 ##1 mem_dqs_o == 2'h3)
    else $error("write strobe preamble wrong");
  wpst_a: assert property ($rose(is_wr) |-> ##5 mem_dqs_o == 2'h3
    ##1 mem_dqs_o == 2'h0 && mem_dq_oe == 2'h0 && mem_dqs_oe == 2'h3 ##1 mem_dqs_oe == 2'h0)
    else $error("write strobe postamble wrong");
  xp_gap_a: assert property ($rose(mem_cke) |-> is_nop [*2])
    else $error("command too soon after power-down exit");
  xsr_gap_a: assert property ($rose(mem_cke) && sr_r |-> is_nop [*4])
    else $error("command too soon after self refresh exit");
  rd_ret_a: assert property ($rose(is_rd) |-> !rd_valid [*8] ##5 rd_valid ##1 !rd_valid)
    else $error("read data returned at wrong time");
endmodule : lpdc_host_monitor
bind lpdc_host lpdc_host_monitor u_mon (.clk, .resetn, .rd_valid, .mem_ck, .mem_ck_n, .mem_cke, .mem_cs_n,
  .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_a, .mem_dq_oe, .mem_dqs_o, .mem_dqs_oe);
`default_nettype wire

// file: verification/lpdc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// memory device model
module lpdc_mem_model (
  input wire logic clk,
  input wire logic [3:0] cmd,
  input wire logic [1:0] mem_ba,
  input wire logic [12:0] mem_a,
  input wire logic [15:0] mem_dq_o,
  input wire logic [1:0] mem_dq_oe,
  input wire logic [1:0] mem_dm_o,
  output logic [15:0] mem_dq_i
);
  logic [63:0] store [logic [10:0]];
  logic [10:0] wkey;
  logic [10:0] rkey;
  int wi = 0;
  int rc = 0;
  initial mem_dq_i = 16'h0;
  always @(negedge clk) begin
    if (cmd == lpdc_pkg::PIN_WR)
      wkey = {mem_ba, mem_a[8:0]};
    if (mem_dq_oe == 2'h0)
      wi = 0;
    else begin
      for (int l = 0; l < 2; l++)
        if (mem_dq_oe[l] && !mem_dm_o[l])
          store[wkey][16*wi+8*l +: 8] = mem_dq_o[8*l +: 8];
      wi++;
    end
  end
  always @(posedge clk) begin
    if (cmd == lpdc_pkg::PIN_RD && rc == 0) begin
      rkey = {mem_ba, mem_a[8:0]};
      rc = 2;
    end else if (rc != 0) begin
      if (rc >= 5 && rc <= 8)
        mem_dq_i <= store[rkey][16*(rc-5) +: 16];
      else if (rc == 9)
        mem_dq_i <= ~mem_dq_i;
      rc = (rc == 9) ? 0 : rc + 1;
    end
  end
endmodule : lpdc_mem_model
`default_nettype wire

// file: verification/lpdc_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench
module lpdc_host_tb_top;
  localparam int CK = lpdc_pkg::CK_DIV;
  localparam int TCK = lpdc_pkg::TCK_PS;
  localparam int WR_CK = (lpdc_pkg::WR_S_PS + TCK - 1) / TCK;
  localparam int RP_CK = (lpdc_pkg::RP_S_PS + TCK - 1) / TCK;
  localparam int RRD_CK = (lpdc_pkg::RRD_S_PS + TCK - 1) / TCK;
  localparam int BURST = lpdc_pkg::WL_CK + lpdc_pkg::BURST_CK;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  lpdc_pkg::lpdc_cmd_e req_cmd = lpdc_pkg::C_ACT;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0;
  logic [63:0] req_wdata = 64'h0;
  logic [7:0] req_wmask = 8'h0;
  logic req_ready, rd_valid, mem_ck, mem_ck_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [1:0] mem_ba, mem_dq_oe, mem_dqs_o, mem_dqs_oe, mem_dm_o;
  logic [12:0] mem_a;
  logic [63:0] rd_data;
  logic [15:0] mem_dq_o, mem_dq_i;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t_iss, t0;
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  lpdc_host uut (.clk, .resetn, .req_valid, .req_ready, .req_cmd, .req_bank, .req_addr, .req_wdata,
    .req_wmask, .rd_valid, .rd_data, .mem_ck, .mem_ck_n, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n,
    .mem_we_n, .mem_ba, .mem_a, .mem_dq_o, .mem_dq_oe, .mem_dq_i, .mem_dqs_o, .mem_dqs_oe, .mem_dm_o);
  lpdc_mem_model mdl (.clk, .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .mem_ba, .mem_a,
    .mem_dq_o, .mem_dq_oe, .mem_dm_o, .mem_dq_i);
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_hi(input bit rd);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 200) begin
        errors++;
        give_verdict();
      end
    end while (rd ? rd_valid !== 1'b1 : req_ready !== 1'b1);
  endtask : wait_hi
  task automatic send(input lpdc_pkg::lpdc_cmd_e c, input logic [1:0] b, input logic [12:0] a,
                      input logic [63:0] d, input logic [7:0] m);
    t0 = t_iss;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= d;
    req_wmask <= m;
    wait_hi(0);
    req_valid <= 1'b0;
    wait_hi(0);
    t_iss = cyc;
  endtask : send
  task automatic t_act_pair;
    send(lpdc_pkg::C_ACT, 2'h1, 13'h005, 64'h0, 8'h0);
    send(lpdc_pkg::C_ACT, 2'h2, 13'h006, 64'h0, 8'h0);
    chk(64'(t_iss - t0 >= RRD_CK * CK), 64'h1);
  endtask : t_act_pair
  task automatic t_wr_mask;
    send(lpdc_pkg::C_WRITE, 2'h1, 13'h008, 64'h0123_4567_89ab_cdef, 8'h00);
    send(lpdc_pkg::C_WRITE, 2'h1, 13'h008, 64'hfedc_ba98_7654_3210, 8'h04);
    send(lpdc_pkg::C_READ, 2'h1, 13'h008, 64'h0, 8'h0);
    chk(64'(t_iss - t0 >= (BURST + lpdc_pkg::WTR_CK) * CK), 64'h1);
    wait_hi(1);
    chk(rd_data, 64'hfedc_ba98_76ab_3210);
  endtask : t_wr_mask
  task automatic t_autopre;
    send(lpdc_pkg::C_WRITE, 2'h1, 13'h408, 64'h5a5a_a5a5_3c3c_c3c3, 8'h00);
    send(lpdc_pkg::C_ACT, 2'h1, 13'h005, 64'h0, 8'h0);
    chk(64'(t_iss - t0 >= (BURST + WR_CK + RP_CK) * CK), 64'h1);
    send(lpdc_pkg::C_READ, 2'h1, 13'h408, 64'h0, 8'h0);
    wait_hi(1);
    chk(rd_data, 64'h5a5a_a5a5_3c3c_c3c3);
  endtask : t_autopre
  task automatic t_power;
    send(lpdc_pkg::C_PRE, 2'h0, 13'h400, 64'h0, 8'h0);
    send(lpdc_pkg::C_REF, 2'h0, 13'h000, 64'h0, 8'h0);
    chk(64'(mem_cke), 64'h1);
    send(lpdc_pkg::C_PDE, 2'h0, 13'h000, 64'h0, 8'h0);
    chk(64'(mem_cke), 64'h0);
    send(lpdc_pkg::C_EXIT, 2'h0, 13'h000, 64'h0, 8'h0);
    chk(64'(mem_cke), 64'h1);
    send(lpdc_pkg::C_SRE, 2'h0, 13'h000, 64'h0, 8'h0);
    chk(64'(mem_cke), 64'h0);
    send(lpdc_pkg::C_ACT, 2'h1, 13'h005, 64'h0, 8'h0);
    chk(64'(mem_cke), 64'h1);
    send(lpdc_pkg::C_READ, 2'h1, 13'h008, 64'h0, 8'h0);
    wait_hi(1);
    chk(rd_data, 64'h5a5a_a5a5_3c3c_c3c3);
  endtask : t_power
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_act_pair();
    t_wr_mask();
    t_autopre();
    t_power();
    give_verdict();
  end
endmodule : lpdc_host_tb_top
`default_nettype wire
